// [verif/ccr_pcm_peer.sv]
// PCM DSP model: bit clock, frame sync, one received byte sent and one transmit slot captured.
`timescale 1ns/1ps
module ccr_pcm_peer (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Bench side
  input  wire logic [7:0] rx_byte_i,
  input  wire logic [4:0] first_i,
  output logic      [7:0] tx_cap_o,
  output logic      [7:0] oe_cap_o,
  output int              frames_o,
  // PCM link
  input  wire logic       tx_i,
  input  wire logic       tx_oe_n_i,
  output logic            bclk_o,
  output logic            fs_o,
  output logic            rx_o
);
  int ph;
  int bt;
  int fst;

  assign fst = int'(first_i);

  ////////////////////////////////////////////////////////////////////////////////
  // Ten core cycles per bit, 32 bits per frame; slot bit i sits at bit time first_i + i.
  // The bench sets first_i to match the timing mode and channel it programs.
  // Outside the slot the data line toggles, since nothing holds it at a known level.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ph       <= 0;
      bt       <= 31;
      bclk_o   <= 1'b0;
      fs_o     <= 1'b0;
      rx_o     <= 1'b0;
      frames_o <= 0;
      tx_cap_o <= 8'h00;
      oe_cap_o <= 8'h00;
    end
    else
    begin
      ph <= (ph == 9) ? 0 : ph + 1;
      if (ph == 9)
      begin
        bclk_o <= 1'b1;
        bt     <= (bt == 31) ? 0 : bt + 1;
      end
      if (ph == 4)
        bclk_o <= 1'b0;
      if (ph == 6)
        fs_o <= (bt == 31);
      if (ph == 1)
        rx_o <= (bt >= fst && bt <= fst + 7) ? rx_byte_i[3'(7 - bt + fst)] : ~rx_o;
      if (ph == 7 && bt >= fst && bt <= fst + 7)
      begin
        tx_cap_o <= {tx_cap_o[6:0], tx_i};
        oe_cap_o <= {oe_cap_o[6:0], tx_oe_n_i};
      end
      if (ph == 7 && bt == fst + 8)
        frames_o <= frames_o + 1;
    end
  end
endmodule

// [verif/ccr_top_tb.sv]
// Self-checking bench for the codec control register set.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin failures++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module ccr_top_tb;
  import ccr_pkg::*;
  logic        core_clk_i, sys_rst_i, ce_i, ctl_cs_n_i, ctl_sclk_i, ctl_sdi_i;
  logic        ctl_sdo_o, ctl_sdo_oe_n_o, mclk_present_i, aux_clk_in_i;
  logic        pcm_bclk_i, pcm_fs_i, pcm_rx_in_i, pcm_tx_out_o, pcm_tx_oe_n_o;
  logic [15:0] enc_word_i, dec_word_o;
  logic        dec_valid_o, mute_o, remote_in_n_i, remote_out_o, buzzer_o, latch_out_pin_o;
  ccr_cfg_s    cfg_o;
  logic [7:0]  rx_byte, tx_cap, oe_cap, v, a, b, t;
  logic [3:0]  regs [10] = '{REG_FMT, REG_PATH, REG_RXA, REG_TXA, REG_TONE1, REG_TONE2,
                            REG_REM, REG_BUZ, 4'h5, 4'hc};
  logic [7:0]  bz [7] = '{8'h3f, 8'h80, 8'hbf, 8'hc0, 8'h80, 8'hc0, 8'h95};
  logic [7:0]  tm [4] = '{8'h88, 8'hc8, 8'h0a, 8'h0a};
  logic [4:0]  fb [4] = '{5'h00, 5'h00, 5'h09, 5'h0b};
  logic [4:0]  first;
  int          frames, seed, failures, n_tests, cyc, n;

  ccr_top #(.DEB_CYC(8)) u_dut (.core_clk_i, .sys_rst_i, .ce_i, .ctl_cs_n_i, .ctl_sclk_i,
    .ctl_sdi_i, .ctl_sdo_o, .ctl_sdo_oe_n_o, .mclk_present_i, .aux_clk_in_i, .pcm_bclk_i,
    .pcm_fs_i, .pcm_rx_in_i, .pcm_tx_out_o, .pcm_tx_oe_n_o, .enc_word_i, .dec_word_o,
    .dec_valid_o, .mute_o, .cfg_o, .remote_in_n_i, .remote_out_o, .buzzer_o, .latch_out_pin_o);

  ccr_pcm_peer u_peer (.clk_i(core_clk_i), .rst_i(sys_rst_i), .rx_byte_i(rx_byte), .first_i(first),
    .tx_cap_o(tx_cap), .oe_cap_o(oe_cap), .frames_o(frames), .tx_i(pcm_tx_out_o),
    .tx_oe_n_i(pcm_tx_oe_n_o), .bclk_o(pcm_bclk_i), .fs_o(pcm_fs_i), .rx_o(pcm_rx_in_i));

  initial
  begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs roughly 15000 cycles.
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      failures++;
      tally_and_finish;
    end
  end

  // Sclk low for three core cycles and high for four; sdo is taken just before the next fall.
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    @(posedge core_clk_i) ctl_cs_n_i <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      @(posedge core_clk_i);
      ctl_sclk_i <= 1'b0;
      ctl_sdi_i  <= sh[i];
      repeat (3) @(posedge core_clk_i);
      ctl_sclk_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      rd = {rd[6:0], ctl_sdo_o};
    end
    `CHK(ctl_sdo_oe_n_o, ~cmd[CMD_RD_BIT])
    @(posedge core_clk_i) ctl_sclk_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    ctl_cs_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
  endtask

  task automatic wr(input logic [3:0] r, input logic [7:0] d);
    logic [7:0] dummy;
    xfer({4'h0, r}, d, dummy);
  endtask

  task automatic rd(input logic [3:0] r, output logic [7:0] d);
    xfer({4'h8, r}, 8'h00, d);
  endtask

  task automatic frame_wait(input int k);
    int f;
    f = frames;
    while (frames < f + k)
      @(posedge core_clk_i);
  endtask

  task automatic press(input logic lvl);
    @(posedge core_clk_i) remote_in_n_i <= lvl;
    repeat (40) @(posedge core_clk_i);
  endtask

  function automatic logic [6:0] pwm_high(input logic [7:0] c);
    if (!c[BUZ_ON])
      return 7'h00;
    return c[BUZ_POL] ? 7'h40 - {1'b0, c[5:0]} : {1'b0, c[5:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'h2c88;
    {failures, n_tests, cyc} = '0;
    {sys_rst_i, ce_i, ctl_cs_n_i, ctl_sclk_i, ctl_sdi_i} = 5'b11100;
    {mclk_present_i, aux_clk_in_i, remote_in_n_i} = 3'b111;
    enc_word_i = 16'h0000;
    rx_byte = 8'h00;
    first = 5'h01;
    repeat (4) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge core_clk_i);
    `CHK(latch_out_pin_o, 1'b1)
    `CHK(buzzer_o, 1'b0)
    foreach (regs[i])
    begin
      rd(regs[i], v);
      `CHK(v, 8'h00)
    end
    repeat (4)
    begin
      a = 8'($random(seed));
      b = 8'($random(seed));
      wr(REG_TONE1, a);
      wr(REG_TONE2, b);
      `CHK(cfg_o.tone_one, a)
      `CHK(cfg_o.tone_two, b)
      rd(REG_TONE2, v);
      `CHK(v, b)
    end
    for (int k = 0; k < 4; k++)
    begin
      v = {2'(k), 6'($random(seed)) & 6'h3e};
      wr(REG_FMT, v);
      `CHK(cfg_o.clk_div_sel, v[7:6])
      `CHK(cfg_o.law_sel, v[4:3])
      `CHK(cfg_o.companded_sel, v[FMT_COMP])
    end
    for (int k = 0; k < 3; k++)
    begin
      wr(REG_REM, 8'(k));
      `CHK(cfg_o.tone_range, 2'(k))
    end
    foreach (bz[i])
    begin
      t = (i < 4) ? bz[i] : {bz[i][7:6], 6'($random(seed))};
      wr(REG_BUZ, t);
      n = 0;
      repeat (64)
      begin
        @(posedge core_clk_i);
        n += (buzzer_o === 1'b1);
      end
      `CHK(7'(n), pwm_high(t))
    end
    wr(REG_PATH, 8'h20);
    `CHK(latch_out_pin_o, 1'b0)
    wr(REG_PATH, 8'h00);
    `CHK(latch_out_pin_o, 1'b1)
    wr(REG_REM, 8'h80);
    press(1'b0);
    `CHK(remote_out_o, 1'b1)
    rd(REG_REM, v);
    `CHK(v, 8'h90)
    press(1'b1);
    `CHK(remote_out_o, 1'b0)
    wr(REG_REM, 8'ha0);
    rd(REG_REM, v);
    `CHK(v, 8'ha0)
    `CHK(remote_out_o, 1'b1)
    wr(REG_REM, 8'hc0);
    press(1'b0);
    press(1'b1);
    `CHK(remote_out_o, 1'b1)

    ////////////////////////////////////////////////////////////////////////////////
    wr(REG_FMT, 8'h20);
    enc_word_i <= 16'($random(seed));
    frame_wait(2);
    `CHK(tx_cap, enc_word_i[7:0])
    wr(REG_PATH, 8'h08);
    t = 8'($random(seed));
    wr(REG_TXA, t);
    frame_wait(2);
    `CHK(tx_cap, t)
    `CHK(oe_cap, 8'h00)
    wr(REG_FMT, 8'h22);
    frame_wait(2);
    `CHK(tx_cap[7:1], t[7:1])
    `CHK(oe_cap, 8'h01)
    wr(REG_FMT, 8'h20);
    wr(REG_PATH, 8'h10);
    rx_byte <= 8'h5a;
    wr(REG_RXA, 8'hc3);
    frame_wait(2);
    for (n = 0; n < 1000 && dec_valid_o !== 1'b1; n++)
      @(posedge core_clk_i);
    `CHK(dec_word_o[7:0], 8'hc3)
    wr(REG_PATH, 8'h00);
    wr(REG_FMT, 8'h21);
    rx_byte <= 8'($random(seed));
    frame_wait(3);
    `CHK(tx_cap, rx_byte)
    `CHK(mute_o, 1'b1)
    `CHK(cfg_o.loopback_on, 1'b1)
    rd(REG_RXA, v);
    `CHK(v, rx_byte)
    // Non-delayed normal and reverse timing, then the second channel without and with the gap.
    for (int k = 0; k < 4; k++)
    begin
      wr(REG_PATH, tm[k]);
      wr(REG_FMT, (k == 3) ? 8'h24 : 8'h20);
      first <= fb[k];
      t = 8'($random(seed));
      wr(REG_TXA, t);
      frame_wait(2);
      `CHK(tx_cap, t)
      `CHK(oe_cap, 8'h00)
      rd(REG_RXA, v);
      `CHK(v, rx_byte)
    end
    wr(REG_PATH, 8'h00);
    wr(REG_FMT, 8'h00);
    first <= 5'h01;
    enc_word_i <= 16'($random(seed));
    frame_wait(2);
    `CHK(tx_cap, enc_word_i[15:8])
    `CHK(dec_word_o[15:8], rx_byte)
    wr(REG_FMT, 8'h20);
    mclk_present_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    `CHK(mute_o, 1'b1)
    `CHK(cfg_o.tone_run, 1'b1)
    `CHK(cfg_o.loopback_on, 1'b0)
    aux_clk_in_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    `CHK(cfg_o.tone_run, 1'b0)
    {mclk_present_i, aux_clk_in_i} <= 2'b11;
    sys_rst_i <= 1'b1;
    @(posedge core_clk_i) sys_rst_i <= 1'b0;
    rd(REG_TONE1, v);
    `CHK(v, 8'h00)
    tally_and_finish;
  end
endmodule

// [verilog/ccr_pkg.sv]
// Shared constants, types and field positions of the codec control register set.
package ccr_pkg;

  // Register numbers carried in the low nibble of the command byte.
  localparam logic [3:0] REG_FMT   = 4'h0;
  localparam logic [3:0] REG_PATH  = 4'h1;
  localparam logic [3:0] REG_RXA   = 4'h2;
  localparam logic [3:0] REG_TXA   = 4'h3;
  localparam logic [3:0] REG_TONE1 = 4'h8;
  localparam logic [3:0] REG_TONE2 = 4'h9;
  localparam logic [3:0] REG_REM   = 4'ha;
  localparam logic [3:0] REG_BUZ   = 4'hb;

  // Command byte layout.
  localparam int CMD_RD_BIT = 7;

  // Field positions.
  localparam int FMT_LOOP   = 0;
  localparam int FMT_SEVEN  = 1;
  localparam int FMT_GAP    = 2;
  localparam int FMT_COMP   = 5;
  localparam int PATH_TS    = 1;
  localparam int PATH_HTX   = 3;
  localparam int PATH_HRX   = 4;
  localparam int PATH_LATCH = 5;
  localparam int PATH_TLO   = 6;
  localparam int PATH_THI   = 7;
  localparam int REM_FLAG   = 4;
  localparam int REM_INV    = 5;
  localparam int REM_LATCH  = 6;
  localparam int REM_EN     = 7;
  localparam int BUZ_POL    = 6;
  localparam int BUZ_ON     = 7;

  // Reset values.
  localparam logic [7:0] RST_REG = 8'h00;

  // Slot geometry in bit times.
  localparam logic [6:0] SLOT_LEN_COMP = 7'h08;
  localparam logic [6:0] SLOT_LEN_LIN  = 7'h10;
  localparam logic [6:0] SLOT_B2       = 7'h08;
  localparam logic [6:0] SLOT_GAP      = 7'h02;
  localparam logic [6:0] POS_IDLE      = 7'h7e;
  localparam logic [6:0] POS_PRE       = 7'h7f;

  // Debounce time of the remote-control input.
  localparam int DEBOUNCE_MS  = 50;
  localparam int CLK_KHZ      = 20000;
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;

  typedef enum logic [1:0] {S_CMD, S_DATA, S_DONE} ccr_ser_e;

  typedef struct packed {
    logic [1:0] clk_div_sel;
    logic [1:0] law_sel;
    logic       companded_sel;
    logic       loopback_on;
    logic [1:0] tone_range;
    logic       tone_run;
    logic [7:0] tone_one;
    logic [7:0] tone_two;
  } ccr_cfg_s;

endpackage

// [verilog/ccr_top.sv]
// Control register set with serial command port, PCM slot engine, remote and buzzer.
`timescale 1ns/1ps
// Contract
// - Tone one word drives first tone frequency.
// - Tone two word drives second tone frequency.
// - Bit six picks transparent or latched indication.
// - Bit five inverts button indication output.
// - Detection sets flag; host write clears it.
// - Range bits pick standard, half, double; 11 forbidden.
// - Buzzer bit seven enables, else output low.
// - Bit six picks high or low duty.
// - Six-bit duty word sets PWM width.
// - Two bits select the input clock divider.
// - Without master clock only tone and buzzer.
// - Law bits pick companding law or linear code.
// - Bit five picks linear or companded coding.
// - Gap bit separates B channels by two.
// - Seven-bit mode drops and floats the LSB.
// - Loopback returns received slot, mutes, no coding.
// - Timing bits pick delayed, normal, reverse framing.
// - Latch pin drives inverse of its bit.
// - Host receive access feeds decoder, reads capture.
// - Host transmit access replaces encoder output.
// - PCM words travel most significant bit first.
module ccr_top
  import ccr_pkg::*;
#(
  parameter int DEB_CYC = DEBOUNCE_CYC
)(
  // Clock, reset, enable
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  // Serial control port
  input  wire logic        ctl_cs_n_i,
  input  wire logic        ctl_sclk_i,
  input  wire logic        ctl_sdi_i,
  output logic             ctl_sdo_o,
  output logic             ctl_sdo_oe_n_o,
  // Clock presence
  input  wire logic        mclk_present_i,
  input  wire logic        aux_clk_in_i,
  // PCM link
  input  wire logic        pcm_bclk_i,
  input  wire logic        pcm_fs_i,
  input  wire logic        pcm_rx_in_i,
  output logic             pcm_tx_out_o,
  output logic             pcm_tx_oe_n_o,
  // Codec core
  input  wire logic [15:0] enc_word_i,
  output logic      [15:0] dec_word_o,
  output logic             dec_valid_o,
  output logic             mute_o,
  output ccr_cfg_s         cfg_o,
  // Phone functions
  input  wire logic        remote_in_n_i,
  output logic             remote_out_o,
  output logic             buzzer_o,
  output logic             latch_out_pin_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  fmt;
  logic [7:0]  path;
  logic [7:0]  rxa;
  logic [7:0]  txa;
  logic [7:0]  tone1;
  logic [7:0]  tone2;
  logic [7:0]  rem;
  logic [7:0]  buz;
  logic [15:0] rx_last;
  ccr_ser_e    st;
  logic        sclk_q;
  logic [2:0]  bit_cnt;
  logic [7:0]  sh;
  logic [7:0]  cmd;
  logic [7:0]  rd_sh;
  logic [7:0]  rd_data;
  logic        wr_stb;
  logic [3:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        s_rise;
  logic        s_fall;
  logic [7:0]  new_cmd;

  assign s_rise  = ctl_sclk_i & ~sclk_q;
  assign s_fall  = ~ctl_sclk_i & sclk_q;
  assign new_cmd = {sh[6:0], ctl_sdi_i};

  // Read mux; the receive access register reads back the captured PCM byte.
  always_comb
  begin
    case (new_cmd[3:0])
      REG_FMT:   rd_data = fmt;
      REG_PATH:  rd_data = path;
      REG_RXA:   rd_data = rx_last[15:8];
      REG_TONE1: rd_data = tone1;
      REG_TONE2: rd_data = tone2;
      REG_REM:   rd_data = rem;
      REG_BUZ:   rd_data = buz;
      default:   rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-byte serial instruction: command byte, then data byte.
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      st             <= S_CMD;
      sclk_q         <= 1'b0;
      bit_cnt        <= 3'h0;
      sh             <= 8'h00;
      cmd            <= 8'h00;
      rd_sh          <= 8'h00;
      wr_stb         <= 1'b0;
      wr_addr        <= 4'h0;
      wr_data        <= 8'h00;
      ctl_sdo_o      <= 1'b0;
      ctl_sdo_oe_n_o <= 1'b1;
    end
    else if (ce_i)
    begin
      sclk_q <= ctl_sclk_i;
      wr_stb <= 1'b0;
      if (ctl_cs_n_i)
      begin
        st             <= S_CMD;
        bit_cnt        <= 3'h0;
        ctl_sdo_oe_n_o <= 1'b1;
      end
      else
      begin
        case (st)
          S_CMD:
          begin
            if (s_rise)
            begin
              sh      <= new_cmd;
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7)
              begin
                cmd   <= new_cmd;
                rd_sh <= rd_data;
                st    <= S_DATA;
              end
            end
          end
          S_DATA:
          begin
            if (s_fall && cmd[CMD_RD_BIT])
            begin
              ctl_sdo_o      <= rd_sh[7];
              rd_sh          <= {rd_sh[6:0], 1'b0};
              ctl_sdo_oe_n_o <= 1'b0;
            end
            if (s_rise)
            begin
              sh      <= new_cmd;
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7)
              begin
                st      <= S_DONE;
                wr_stb  <= ~cmd[CMD_RD_BIT];
                wr_addr <= cmd[3:0];
                wr_data <= new_cmd;
              end
            end
          end
          S_DONE:  st <= S_DONE;
          default: st <= S_CMD;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain control registers.
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      fmt             <= RST_REG;
      path            <= RST_REG;
      rxa             <= RST_REG;
      txa             <= RST_REG;
      tone1           <= RST_REG;
      tone2           <= RST_REG;
      buz             <= RST_REG;
      latch_out_pin_o <= 1'b1;
    end
    else if (ce_i && wr_stb)
    begin
      case (wr_addr)
        REG_FMT:   fmt   <= wr_data;
        REG_PATH:
        begin
          path            <= wr_data;
          latch_out_pin_o <= ~wr_data[PATH_LATCH];
        end
        REG_RXA:   rxa   <= wr_data;
        REG_TXA:   txa   <= wr_data;
        REG_TONE1: tone1 <= wr_data;
        REG_TONE2: tone2 <= wr_data;
        REG_BUZ:   buz   <= wr_data;
        default:   fmt   <= fmt;
      endcase
    end
  end

  chk_latch_pin_inv: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (ce_i && wr_stb && wr_addr == REG_PATH) |=>
      (latch_out_pin_o == !$past(wr_data[PATH_LATCH])))
    else $error("latch pin does not show the inverse of its bit");

  ////////////////////////////////////////////////////////////////////////////
  // Configuration to the analog and tone core. Tone runs on either clock.
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      cfg_o <= '0;
    else if (ce_i)
    begin
      cfg_o.clk_div_sel   <= fmt[7:6];
      cfg_o.law_sel       <= fmt[4:3];
      cfg_o.companded_sel <= fmt[FMT_COMP];
      cfg_o.loopback_on   <= fmt[FMT_LOOP];
      cfg_o.tone_range    <= rem[1:0];
      cfg_o.tone_run      <= mclk_present_i | aux_clk_in_i;
      cfg_o.tone_one      <= tone1;
      cfg_o.tone_two      <= tone2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Remote-control button detection with debounce.
  logic [31:0] deb_cnt;
  logic        pressed;
  logic        rem_evt;

  assign rem_evt = (deb_cnt == 32'(DEB_CYC - 1)) && !remote_in_n_i && !pressed && rem[REM_EN];

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      deb_cnt <= 32'h0;
      pressed <= 1'b0;
    end
    else if (ce_i)
    begin
      if ((!remote_in_n_i) == pressed)
        deb_cnt <= 32'h0;
      else if (deb_cnt == 32'(DEB_CYC - 1))
      begin
        deb_cnt <= 32'h0;
        pressed <= !remote_in_n_i;
      end
      else
        deb_cnt <= deb_cnt + 32'h1;
    end
  end

  // A detection in the write cycle wins over the host's clear.
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      rem <= RST_REG;
    else if (ce_i)
    begin
      if (wr_stb && wr_addr == REG_REM)
        rem <= {wr_data[7:5], wr_data[REM_FLAG] & rem[REM_FLAG], wr_data[3:0]};
      if (rem_evt)
        rem[REM_FLAG] <= 1'b1;
    end
  end

  chk_rem_flag_set: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (ce_i && rem_evt) |=> rem[REM_FLAG])
    else $error("detection did not set the flag");

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      remote_out_o <= 1'b0;
    else if (ce_i)
      remote_out_o <= (rem[REM_LATCH] ? rem[REM_FLAG] : pressed) ^ rem[REM_INV];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buzzer PWM; the duty word names the high or the low part of the period.
  logic [5:0] pwm_cnt;
  logic       buz_ok;

  assign buz_ok = buz[BUZ_ON] & (mclk_present_i | aux_clk_in_i);

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      pwm_cnt  <= 6'h00;
      buzzer_o <= 1'b0;
    end
    else if (ce_i)
    begin
      pwm_cnt  <= pwm_cnt + 6'h01;
      buzzer_o <= buz_ok & ((pwm_cnt < buz[5:0]) ^ buz[BUZ_POL]);
    end
  end

  chk_buz_off_low: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (ce_i && !buz[BUZ_ON]) |=> !buzzer_o)
    else $error("buzzer active while disabled");

  chk_buz_duty_hi: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (ce_i && buz_ok && !buz[BUZ_POL] && pwm_cnt < buz[5:0]) |=> buzzer_o)
    else $error("buzzer low inside high part of duty");

  ////////////////////////////////////////////////////////////////////////////
  // PCM slot engine. Bit clock and frame sync are sampled by the core clock,
  // so the core clock must run well above the bit clock.
  logic        bclk_q;
  logic        fs_prev;
  logic [6:0]  pos;
  logic [6:0]  next_pos;
  logic [6:0]  s_start;
  logic [6:0]  s_len;
  logic [15:0] tx_sh;
  logic [15:0] rx_sh;
  logic [15:0] rx_new;
  logic [15:0] tx_word;
  logic        comp;
  logic        delayed;
  logic        rev;
  logic        drv_edge;
  logic        smp_edge;
  logic        f_start;
  logic        nxt_in;
  logic        cur_in;
  logic        lsb_fl;

  assign comp     = fmt[FMT_COMP];
  assign delayed  = ~path[PATH_THI];
  assign rev      = path[PATH_THI] & path[PATH_TLO];
  assign drv_edge = rev ? (~pcm_bclk_i & bclk_q) : (pcm_bclk_i & ~bclk_q);
  assign smp_edge = rev ? (pcm_bclk_i & ~bclk_q) : (~pcm_bclk_i & bclk_q);
  assign f_start  = drv_edge & pcm_fs_i & ~fs_prev;
  assign s_len    = comp ? SLOT_LEN_COMP : SLOT_LEN_LIN;
  // The B2 channel starts right after B1 or two bit times later.
  assign s_start  = (comp && path[PATH_TS]) ? (SLOT_B2 + (fmt[FMT_GAP] ? SLOT_GAP : 7'h00))
                                            : 7'h00;
  assign next_pos = f_start ? (delayed ? POS_PRE : 7'h00)
                            : ((pos == POS_IDLE) ? pos : pos + 7'h01);
  assign nxt_in   = (next_pos >= s_start) && (next_pos < s_start + s_len);
  assign cur_in   = (pos >= s_start) && (pos < s_start + s_len);
  assign lsb_fl   = comp && fmt[FMT_SEVEN] && (next_pos == s_start + 7'h07);
  assign rx_new   = {rx_sh[14:0], pcm_rx_in_i};

  // Source of the transmitted word.
  always_comb
  begin
    if (fmt[FMT_LOOP])
      tx_word = rx_last;
    else if (comp && path[PATH_HTX])
      tx_word = {txa, 8'h00};
    else if (comp)
      tx_word = {enc_word_i[7:0], 8'h00};
    else
      tx_word = enc_word_i;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      bclk_q        <= 1'b0;
      fs_prev       <= 1'b0;
      pos           <= POS_IDLE;
      tx_sh         <= 16'h0000;
      pcm_tx_out_o  <= 1'b0;
      pcm_tx_oe_n_o <= 1'b1;
    end
    else if (ce_i)
    begin
      bclk_q <= pcm_bclk_i;
      if (drv_edge)
      begin
        fs_prev <= pcm_fs_i;
        pos     <= next_pos;
        if (nxt_in && next_pos == s_start)
        begin
          pcm_tx_out_o <= tx_word[15];
          tx_sh        <= {tx_word[14:0], 1'b0};
        end
        else
        begin
          pcm_tx_out_o <= tx_sh[15];
          tx_sh        <= {tx_sh[14:0], 1'b0};
        end
        pcm_tx_oe_n_o <= ~(nxt_in & mclk_present_i & ~lsb_fl);
      end
    end
  end

  chk_tx_out_slot: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (ce_i && drv_edge && !nxt_in) |=> pcm_tx_oe_n_o)
    else $error("transmit driven outside its slot");

  chk_tx_lsb_float: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (ce_i && drv_edge && lsb_fl) |=> pcm_tx_oe_n_o)
    else $error("seven-bit mode drove the LSB");

  chk_host_tx_msb: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (ce_i && drv_edge && nxt_in && next_pos == s_start && comp && !fmt[FMT_LOOP]
     && path[PATH_HTX]) |=> (pcm_tx_out_o == $past(txa[7])))
    else $error("host transmit byte not sent MSB first");

  // Receive capture and delivery to the decoder.
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      rx_sh       <= 16'h0000;
      rx_last     <= 16'h0000;
      dec_word_o  <= 16'h0000;
      dec_valid_o <= 1'b0;
      mute_o      <= 1'b0;
    end
    else if (ce_i)
    begin
      dec_valid_o <= 1'b0;
      mute_o      <= fmt[FMT_LOOP] | ~mclk_present_i;
      if (smp_edge && cur_in)
      begin
        rx_sh <= rx_new;
        if (pos == s_start + s_len - 7'h01)
        begin
          if (comp)
            rx_last <= {rx_new[7:1], rx_new[0] & ~fmt[FMT_SEVEN], 8'h00};
          else
            rx_last <= rx_new;
          if (!fmt[FMT_LOOP] && !(comp && path[PATH_HRX]) && mclk_present_i)
          begin
            dec_word_o  <= comp ? {8'h00, rx_new[7:1], rx_new[0] & ~fmt[FMT_SEVEN]}
                                : rx_new;
            dec_valid_o <= 1'b1;
          end
        end
      end
      if (f_start && comp && path[PATH_HRX] && !fmt[FMT_LOOP] && mclk_present_i)
      begin
        dec_word_o  <= {8'h00, rxa};
        dec_valid_o <= 1'b1;
      end
    end
  end

  chk_loop_no_dec: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (ce_i && fmt[FMT_LOOP]) |=> (!dec_valid_o && mute_o))
    else $error("loopback still decoding or unmuted");

endmodule
